// file: inc/synth_cfg_map.vh
// Constants for the serially programmed synthesizer control registers.
`ifndef SYNTH_CFG_MAP_VH
`define SYNTH_CFG_MAP_VH

// Frame lengths in serial clocks.
`define LEN_CONFIG 5'h08
`define LEN_REFERENCE 5'h10
`define LEN_DIVIDER 5'h18
`define LEN_MAX 5'h1F

// Configuration byte fields.
`define CFG_POL 7
`define CFG_SEL 6
`define CFG_LDE 5
`define CFG_STANDBY_BIT 4
`define CFG_CUR_HI 3
`define CFG_CUR_LO 2
`define CFG_PORT 1
`define CFG_OUTB 0
`define CFG_RST 8'h00

// Divider word fields.
`define DIV_FUNC_HI 23
`define DIV_FUNC_LO 22
`define DIV_N_HI 17
`define DIV_N_LO 6
`define DIV_A_HI 5
`define DIV_A_LO 0
`define DIV_RST 24'h000000
`define PRESCALE_SHIFT 6

// First general output functions.
`define FUNC_DATA_OUT 2'h0
`define FUNC_REF_DIV 2'h1
`define FUNC_VCO_DIV 2'h2
`define FUNC_PORT 2'h3

// Reference word fields.
`define REF_MODE_HI 15
`define REF_MODE_LO 13
`define REF_RATIO_HI 12
`define REF_RATIO_LO 0
`define REF_RATIO_RST 13'h0000
`define OSC_STATIC_LOW 3'h0
`define OSC_DIV8 3'h3

// Current levels in percent.
`define PCT_25 7'h19
`define PCT_50 7'h32
`define PCT_70 7'h46
`define PCT_75 7'h4B
`define PCT_80 7'h50
`define PCT_90 7'h5A
`define PCT_100 7'h64

`endif

// file: src/synth_serial_config_regs.v
// Serial register file and control decoding of the frequency synthesizer.
`timescale 1ns/1ps
`include "synth_cfg_map.vh"

module synth_serial_config_regs (
   // Clock and reset
   input wire mclk_i,
   input wire rst_i,
   // Serial port pins
   input wire sclk_i,
   input wire sdata_i,
   input wire frame_enable_n_i,
   // Divided signals and raw detector events from the counter core
   input wire ref_divided_freq_i,
   input wire vco_divided_freq_i,
   input wire vco_lead_i,
   input wire ref_lead_i,
   input wire ref_cycle_end_i,
   // Single-ended detector output
   output reg pd_source_o,
   output reg pd_sink_o,
   output reg pd_oe_o,
   // Double-ended detector outputs and lock
   output reg phi_r_o,
   output reg phi_v_o,
   output reg lock_indicator_o,
   // General outputs
   output reg out_a_o,
   output reg out_b_o,
   output reg out_b_oe_o,
   // Counter and analog controls
   output reg counters_run_o,
   output reg rx_current_en_o,
   output reg r_jam_load_o,
   output reg detector_init_o,
   output reg [6:0] current_pct_o,
   output reg [2:0] osc_mode_o,
   output reg osc_feedback_en_o,
   output reg osc_input_en_o,
   output reg [12:0] ref_ratio_o,
   output reg [11:0] n_count_o,
   output reg [5:0] a_count_o,
   output reg [17:0] total_div_o
);

   // Standby sequencer states.
   // ST_RUN is normal operation with detector pulses passed through.
   // ST_STANDBY_BIT holds the counters and the resistor current off while the registers keep their contents.
   // ST_WAIT is the first exit step: counters run again, but detector pulses stay blocked.
   // The first divided VCO pulse seen in ST_WAIT ends the exit and returns to ST_RUN.
   // The fourth code is unused and falls back to ST_RUN through the default branch.
   localparam ST_RUN = 2'h0;
   localparam ST_STANDBY_BIT = 2'h1;
   localparam ST_WAIT = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers.
   //
   // The three serial pins come from the host, which runs on a clock of its own.
   // Each pin passes two flip-flops before any logic looks at it, so that a metastable
   // first stage never reaches the edge detectors or the shift register.
   // Clock and data pass through stages of equal depth, so a data bit keeps its timing
   // relative to the clock edge that takes it.
   // The enable synchroniser resets to its idle high level; a false frame start
   // right after reset is therefore impossible.
   // Only the second stage of each synchroniser feeds the edge history flip-flops.

   reg [1:0] sclk_sync_q;
   reg [1:0] data_sync_q;
   reg [1:0] en_sync_q;
   reg sclk_prev_q;
   reg en_prev_q;

   always @(posedge mclk_i) begin
      if (rst_i) begin
         sclk_sync_q <= 2'h0;
         data_sync_q <= 2'h0;
         en_sync_q <= 2'h3;
         sclk_prev_q <= 1'b0;
         en_prev_q <= 1'b1;
      end else begin
         sclk_sync_q <= {sclk_sync_q[0], sclk_i};
         data_sync_q <= {data_sync_q[0], sdata_i};
         en_sync_q <= {en_sync_q[0], frame_enable_n_i};
         sclk_prev_q <= sclk_sync_q[1];
         en_prev_q <= en_sync_q[1];
      end
   end

   wire sclk_rise = sclk_sync_q[1] & ~sclk_prev_q;
   wire frame_open = ~en_sync_q[1];
   wire frame_start = en_prev_q & ~en_sync_q[1];
   wire frame_end = ~en_prev_q & en_sync_q[1];

   ////////////////////////////////////////////////////////////////////////////
   // Shift register and clock counter.
   //
   // Each serial clock rise inside an open frame shifts one bit in, most significant first.
   // The counter records how many rises the frame held; it stops at its top value so that
   // an overlong frame can never wrap round to a legal length.
   // The bit that falls out of the top of the shift register is kept for the data-out
   // function of the first general output, which lets several devices be chained.

   reg [23:0] shift_q;
   reg [4:0] count_q;
   reg dout_q;

   always @(posedge mclk_i) begin
      if (rst_i) begin
         shift_q <= 24'h000000;
         count_q <= 5'h00;
         dout_q <= 1'b0;
      end else if (frame_start) begin
         count_q <= 5'h00;
      end else if (frame_open && sclk_rise) begin
         shift_q <= {shift_q[22:0], data_sync_q[1]};
         dout_q <= shift_q[23];
         if (count_q != `LEN_MAX) begin
            count_q <= count_q + 5'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers loaded at frame end.
   //
   // No address bits travel with a frame: its length alone picks the register.
   // A frame with no clock rises and the serial clock low only moves the first
   // reference buffer into the second one.
   // The active reference ratio follows the second buffer only when the reference
   // counter ends a count cycle, so a ratio change never cuts a cycle short.

   reg [7:0] cfg_q;
   reg [23:0] div_q;
   reg [2:0] osc_q;
   reg [12:0] ref_buf1_q;
   reg [12:0] ref_buf2_q;

   // Frames of any other nonzero length, such as the fifteen-clock initialisation groups, load nothing.
   wire load_cfg = frame_end && (count_q == `LEN_CONFIG);
   wire load_ref = frame_end && (count_q == `LEN_REFERENCE);
   wire load_div = frame_end && (count_q == `LEN_DIVIDER);
   wire load_xfer = frame_end && (count_q == 5'h00) && ~sclk_sync_q[1];

   always @(posedge mclk_i) begin
      if (rst_i) begin
         cfg_q <= `CFG_RST;
         div_q <= `DIV_RST;
         osc_q <= `OSC_DIV8;
         ref_buf1_q <= `REF_RATIO_RST;
         ref_buf2_q <= `REF_RATIO_RST;
      end else begin
         if (load_cfg) begin
            cfg_q <= shift_q[7:0];
         end
         if (load_ref) begin
            osc_q <= shift_q[`REF_MODE_HI:`REF_MODE_LO];
            ref_buf1_q <= shift_q[`REF_RATIO_HI:`REF_RATIO_LO];
         end
         if (load_div) begin
            div_q <= shift_q;
            ref_buf2_q <= ref_buf1_q;
         end
         if (load_xfer) begin
            ref_buf2_q <= ref_buf1_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Standby sequencing.
   //
   // Setting the standby bit takes effect on the next clock.
   // Clearing it does not go straight to normal running: the counters start first and
   // the detectors stay quiet until the first divided VCO pulse lines both sides up.
   // Setting the standby bit again during that wait goes back to standby at once.

   reg [1:0] state_q;
   reg [1:0] state_d;
   wire standby_bit = cfg_q[`CFG_STANDBY_BIT];

   always @* begin
      state_d = state_q;
      case (state_q)
         ST_RUN: begin
            if (standby_bit) begin
               state_d = ST_STANDBY_BIT;
            end
         end
         ST_STANDBY_BIT: begin
            if (!standby_bit) begin
               state_d = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (standby_bit) begin
               state_d = ST_STANDBY_BIT;
            end else if (vco_divided_freq_i) begin
               state_d = ST_RUN;
            end
         end
         default: begin
            state_d = ST_RUN;
         end
      endcase
   end

   always @(posedge mclk_i) begin
      if (rst_i) begin
         state_q <= ST_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   wire in_standby_bit = (state_q == ST_STANDBY_BIT);
   wire pass_pulses = (state_q == ST_RUN) && !standby_bit;

   ////////////////////////////////////////////////////////////////////////////
   // Output decoding.
   //
   // The polarity bit swaps the two detector events before they reach any output, so the
   // single-ended pair and the double-ended pair both follow it.
   // The detector select bit and standby put the unused outputs at rest: the double-ended
   // pair high and the single-ended output floating.
   // The lock indicator is built from the same next values as the double-ended pair so that
   // it falls in the same cycle as either of them.
   // Every output below is registered, so no decoding glitch reaches a pin.

   wire detector_polarity = cfg_q[`CFG_POL];
   wire sel_single = cfg_q[`CFG_SEL];
   wire lock_output_enable = cfg_q[`CFG_LDE];
   wire port_level = cfg_q[`CFG_PORT];
   wire [1:0] func = div_q[`DIV_FUNC_HI:`DIV_FUNC_LO];
   wire port_mode = (func == `FUNC_PORT);
   wire step25 = !port_mode && port_level;
   wire v_ev = pass_pulses && vco_lead_i;
   wire r_ev = pass_pulses && ref_lead_i;
   wire v_pulse = detector_polarity ? r_ev : v_ev;
   wire r_pulse = detector_polarity ? v_ev : r_ev;
   wire pair_live = !sel_single && !in_standby_bit;
   wire phi_r_d = pair_live ? ~r_pulse : 1'b1;
   wire phi_v_d = pair_live ? ~v_pulse : 1'b1;
   wire single_live = sel_single && !in_standby_bit;
   wire [11:0] n_val = div_q[`DIV_N_HI:`DIV_N_LO];
   wire [5:0] a_val = div_q[`DIV_A_HI:`DIV_A_LO];
   wire static_low_osc = (osc_q == `OSC_STATIC_LOW);

   reg [6:0] pct_d;
   reg out_a_d;
   reg lock_d;

   always @* begin
      case ({step25, cfg_q[`CFG_CUR_HI:`CFG_CUR_LO]})
         3'h0: pct_d = `PCT_70;
         3'h1: pct_d = `PCT_80;
         3'h2: pct_d = `PCT_90;
         3'h4: pct_d = `PCT_25;
         3'h5: pct_d = `PCT_50;
         3'h6: pct_d = `PCT_75;
         default: pct_d = `PCT_100;
      endcase
   end

   always @* begin
      case (func)
         `FUNC_DATA_OUT: out_a_d = dout_q;
         `FUNC_REF_DIV: out_a_d = ref_divided_freq_i;
         `FUNC_VCO_DIV: out_a_d = vco_divided_freq_i;
         default: out_a_d = port_level;
      endcase
   end

   always @* begin
      if (!lock_output_enable) begin
         lock_d = 1'b0;
      end else if (in_standby_bit) begin
         lock_d = 1'b1;
      end else begin
         lock_d = phi_r_d & phi_v_d;
      end
   end

   always @(posedge mclk_i) begin
      if (rst_i) begin
         pd_source_o <= 1'b0;
         pd_sink_o <= 1'b0;
         pd_oe_o <= 1'b0;
         phi_r_o <= 1'b1;
         phi_v_o <= 1'b1;
         lock_indicator_o <= 1'b0;
         out_a_o <= 1'b0;
         out_b_o <= 1'b0;
         out_b_oe_o <= 1'b1;
         counters_run_o <= 1'b0;
         rx_current_en_o <= 1'b0;
         r_jam_load_o <= 1'b0;
         detector_init_o <= 1'b0;
         current_pct_o <= `PCT_70;
         osc_mode_o <= `OSC_DIV8;
         osc_feedback_en_o <= 1'b1;
         osc_input_en_o <= 1'b1;
         ref_ratio_o <= `REF_RATIO_RST;
         n_count_o <= 12'h000;
         a_count_o <= 6'h00;
         total_div_o <= 18'h00000;
      end else begin
         pd_source_o <= single_live && r_pulse;
         pd_sink_o <= single_live && v_pulse;
         pd_oe_o <= single_live && (r_pulse || v_pulse);
         phi_r_o <= phi_r_d;
         phi_v_o <= phi_v_d;
         lock_indicator_o <= lock_d;
         out_a_o <= out_a_d;
         out_b_o <= 1'b0;
         out_b_oe_o <= ~cfg_q[`CFG_OUTB];
         counters_run_o <= !in_standby_bit;
         rx_current_en_o <= !in_standby_bit;
         r_jam_load_o <= (state_q == ST_WAIT) && !standby_bit && vco_divided_freq_i;
         detector_init_o <= (state_q == ST_WAIT) && !standby_bit && vco_divided_freq_i;
         current_pct_o <= pct_d;
         osc_mode_o <= osc_q;
         osc_feedback_en_o <= !(in_standby_bit && static_low_osc);
         osc_input_en_o <= !(in_standby_bit && static_low_osc);
         if (ref_cycle_end_i) begin
            ref_ratio_o <= ref_buf2_q;
         end
         n_count_o <= n_val;
         a_count_o <= a_val;
         total_div_o <= {n_val, a_val};
      end
   end

endmodule

// file: testbench/synth_host_model.sv
// Host side of the serial port: drives clock, data and frame enable.
`timescale 1ns/1ps
module synth_host_model (
   // Clock
   input wire logic mclk_i,
   // Serial port pins
   output logic sclk_o,
   output logic sdata_o,
   output logic frame_enable_n_o
);
   initial begin
      sclk_o = 1'b0;
      sdata_o = 1'b0;
      frame_enable_n_o = 1'b1;
   end
   task automatic step(input int k);
      repeat (k) @(negedge mclk_i);
   endtask
   // Sends the low n bits of w, most significant first; hp is the half period in clocks.
   task automatic send(input logic [23:0] w, input int n, input int hp, input logic hold_hi);
      frame_enable_n_o <= 1'b0;
      step(hp);
      for (int i = n - 1; i >= 0; i--) begin
         sdata_o <= w[i];
         step(hp);
         sclk_o <= 1'b1;
         step(hp);
         sclk_o <= hold_hi && i == 0;
      end
      step(hp);
      frame_enable_n_o <= 1'b1;
      sdata_o <= ~sdata_o;
      step(6);
      sclk_o <= 1'b0;
   endtask
   // A bare enable pulse with the clock low moves the first reference buffer on.
   task automatic xfer();
      frame_enable_n_o <= 1'b0;
      step(4);
      frame_enable_n_o <= 1'b1;
      step(6);
   endtask
endmodule

// file: testbench/synth_serial_config_regs_monitor.sv
// Port checker for the synthesizer serial control registers.
`timescale 1ns/1ps
module synth_serial_config_regs_monitor (
   input logic mclk_i,
   input logic rst_i,
   input logic vco_divided_freq_i,
   input logic ref_cycle_end_i,
   input logic pd_oe_o,
   input logic phi_r_o,
   input logic phi_v_o,
   input logic lock_indicator_o,
   input logic counters_run_o,
   input logic r_jam_load_o,
   input logic [6:0] current_pct_o,
   input logic [12:0] ref_ratio_o,
   input logic [11:0] n_count_o,
   input logic [5:0] a_count_o,
   input logic [17:0] total_div_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   chk_pct_table: assert property (current_pct_o inside {7'h19, 7'h32, 7'h46, 7'h4B, 7'h50, 7'h5A, 7'h64})
      else $error("current level off table");
   chk_lock_and: assert property ($fell(phi_r_o) || $fell(phi_v_o) |-> ##[0:1] !lock_indicator_o)
      else $error("lock high while pair low");
   chk_pair_rest: assert property (pd_oe_o |-> phi_r_o && phi_v_o)
      else $error("pair active with single output on");
   chk_standby_bit_rest: assert property (!counters_run_o |-> !pd_oe_o && phi_r_o && phi_v_o)
      else $error("outputs active while stopped");
   chk_div_total: assert property (total_div_o == {n_count_o, 6'h00} + a_count_o)
      else $error("total division wrong");
   chk_jam_once: assert property (r_jam_load_o |=> !r_jam_load_o)
      else $error("jam load longer than a cycle");
   chk_jam_cause: assert property ($rose(r_jam_load_o) |-> $past(vco_divided_freq_i) && counters_run_o)
      else $error("jam load without divided pulse");
   chk_ratio_wait: assert property (!$stable(ref_ratio_o) |-> $past(ref_cycle_end_i))
      else $error("ratio changed mid cycle");
   cover property ($rose(r_jam_load_o));
   cover property (!$stable(ref_ratio_o));
   cover property (!counters_run_o ##1 counters_run_o);
endmodule
bind synth_serial_config_regs synth_serial_config_regs_monitor mon (.mclk_i, .rst_i, .vco_divided_freq_i,
   .ref_cycle_end_i, .pd_oe_o, .phi_r_o, .phi_v_o, .lock_indicator_o, .counters_run_o, .r_jam_load_o,
   .current_pct_o, .ref_ratio_o, .n_count_o, .a_count_o, .total_div_o);

// file: testbench/synth_serial_config_regs_test.sv
// Self-checking bench for the synthesizer serial control registers.
`timescale 1ns/1ps
module synth_serial_config_regs_test;
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ref_divided_freq_i = 1'b1;
   logic vco_divided_freq_i = 1'b0;
   logic vco_lead_i = 1'b0;
   logic ref_lead_i = 1'b0;
   logic ref_cycle_end_i = 1'b0;
   logic sclk_i, sdata_i, frame_enable_n_i;
   logic pd_source_o, pd_sink_o, pd_oe_o, phi_r_o, phi_v_o, lock_indicator_o, out_a_o, out_b_o, out_b_oe_o;
   logic counters_run_o, rx_current_en_o, r_jam_load_o, detector_init_o, osc_feedback_en_o, osc_input_en_o;
   logic [6:0] current_pct_o;
   logic [2:0] osc_mode_o;
   logic [12:0] ref_ratio_o;
   logic [11:0] n_count_o;
   logic [5:0] a_count_o;
   logic [17:0] total_div_o;
   int n_mismatch = 0;
   int total_checks = 0;
   int cyc = 0;
   int e;
   initial begin
      forever #12.5 mclk_i = ~mclk_i;
   end
   synth_host_model host (.mclk_i, .sclk_o(sclk_i), .sdata_o(sdata_i), .frame_enable_n_o(frame_enable_n_i));
   synth_serial_config_regs dut (.mclk_i, .rst_i, .sclk_i, .sdata_i, .frame_enable_n_i, .ref_divided_freq_i,
      .vco_divided_freq_i, .vco_lead_i, .ref_lead_i, .ref_cycle_end_i, .pd_source_o, .pd_sink_o, .pd_oe_o,
      .phi_r_o, .phi_v_o, .lock_indicator_o, .out_a_o, .out_b_o, .out_b_oe_o, .counters_run_o, .rx_current_en_o,
      .r_jam_load_o, .detector_init_o, .current_pct_o, .osc_mode_o, .osc_feedback_en_o, .osc_input_en_o,
      .ref_ratio_o, .n_count_o, .a_count_o, .total_div_o);
   task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic step(input int k);
      repeat (k) @(negedge mclk_i);
   endtask
   task automatic end_count();
      ref_cycle_end_i = 1'b1;
      step(1);
      ref_cycle_end_i = 1'b0;
      step(2);
   endtask
   task automatic results();
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         results();
      end
   end
   initial begin
      step(6);
      rst_i = 1'b0;
      step(2);
      check("idle", {lock_indicator_o, pd_oe_o, phi_r_o, phi_v_o, out_b_oe_o}, 18'h00007);
      check("osc", {osc_mode_o, current_pct_o}, 18'h001C6);
      check("outa", out_a_o, 18'h00000);
      host.send(24'h007FFF, 15, 3, 1'b1);
      check("init", {osc_mode_o, current_pct_o}, 18'h001C6);
      for (int c = 0; c < 8; c++) begin
         host.send({16'h0000, 4'h0, c[1:0], c[2], c[0]}, 8, 3, 1'b0);
         e = c[2] ? 25 * (c[1:0] + 1) : 70 + 10 * c[1:0];
         check("pct", current_pct_o, 18'(e));
         check("outb", out_b_oe_o, {17'h00000, ~c[0]});
         check("outbv", out_b_o, 18'h00000);
      end
      for (int f = 1; f < 4; f++) begin
         host.send({f[1:0], 22'h000000}, 24, 3, 1'b0);
         host.send(24'h000006, 8, 3, 1'b0);
         check("outa", out_a_o, f == 2 ? 18'h00000 : 18'h00001);
         check("pct", current_pct_o, f == 3 ? 18'h00050 : 18'h00032);
      end
      host.send({8'h00, 3'h5, 13'h0123}, 16, 5, 1'b0);
      end_count();
      check("ref1", {osc_mode_o, ref_ratio_o}, {2'h0, 3'h5, 13'h0000});
      host.xfer();
      check("hold", ref_ratio_o, 18'h00000);
      end_count();
      check("ref2", ref_ratio_o, 18'h00123);
      host.send({8'h00, 3'h3, 13'h0456}, 16, 3, 1'b0);
      host.send({2'h0, 4'h0, 12'h0A5, 6'h21}, 24, 3, 1'b0);
      check("ndiv", {n_count_o, a_count_o}, {12'h0A5, 6'h21});
      check("total", total_div_o, 18'(12'h0A5 * 64 + 6'h21));
      check("cfg", current_pct_o, 18'h00032);
      check("old", ref_ratio_o, 18'h00123);
      end_count();
      check("new", ref_ratio_o, 18'h00456);
      for (int i = 0; i < 4; i++) begin
         host.send({16'h0000, i[1], i[0], 6'h20}, 8, 3, 1'b0);
         vco_lead_i = 1'b1;
         step(2);
         check("pair", {phi_r_o, phi_v_o, lock_indicator_o, pd_oe_o}, i[0] ? 18'h0000F : {14'h0, ~i[1], i[1], 2'h0});
         if (i[0]) check("pd", {pd_source_o, pd_sink_o}, {16'h0000, i[1], ~i[1]});
         vco_lead_i = 1'b0;
         step(2);
         check("lock", lock_indicator_o, 18'h00001);
      end
      host.send(24'h000030, 8, 3, 1'b0);
      check("standby_bit", {pd_oe_o, phi_r_o, phi_v_o, lock_indicator_o, counters_run_o, rx_current_en_o}, 18'h0001C);
      check("keep", n_count_o, 18'h000A5);
      host.send({8'h00, 3'h0, 13'h0456}, 16, 3, 1'b0);
      check("cut", {osc_feedback_en_o, osc_input_en_o}, 18'h00000);
      ref_lead_i = 1'b1;
      host.send(24'h000020, 8, 3, 1'b0);
      check("wait", {counters_run_o, rx_current_en_o, phi_r_o, phi_v_o, osc_feedback_en_o}, 18'h0001F);
      vco_divided_freq_i = 1'b1;
      step(1);
      vco_divided_freq_i = 1'b0;
      check("jam", {r_jam_load_o, detector_init_o}, 18'h00003);
      step(1);
      check("once", r_jam_load_o, 18'h00000);
      step(1);
      check("pass", phi_r_o, 18'h00000);
      results();
   end
endmodule
